// ### src/stc_pkg.sv
// What this block does
// RQ1: sync divisor code picks input clock division
// RQ2: receive rate is sync clock over four
// RQ3: send rate is sync clock over period
// RQ4: async clock range code; codes 5-7 forbidden
// RQ5: reselection answered when its enable is set
// RQ6: reselection never changes the programmed role
// RQ7: selection answered when its enable is set
// RQ8: selection never changes the programmed role
// RQ9: own three-bit id asserted during arbitration
// RQ10: priority runs from id 7 down to 0
// RQ11: period code maps to divisor code plus four
// RQ12: table-indirect load fills whole transfer register
// RQ13: offset code zero async, 1-8 valid, above reserved
// RQ14: synchronous transfer only in data phases
// RQ15: reserved bits ignore writes, read as zero
package stc_pkg;
  // ----------------------------------------
  // register map (printed offsets are word indices)
  // ----------------------------------------
  localparam logic [5:0] IDX_CLKDIV = 6'h03;
  localparam logic [5:0] IDX_OWNID = 6'h04;
  localparam logic [5:0] IDX_PERIOD = 6'h05;
  localparam logic [5:0] IDX_CTRL = 6'h08;
  localparam logic [5:0] IDX_STATUS = 6'h09;
  localparam logic [7:0] MASK_CLKDIV = 8'h77;
  localparam logic [7:0] MASK_OWNID = 8'h67;
  localparam logic [7:0] MASK_PERIOD = 8'hef;
  localparam logic [7:0] MASK_CTRL = 8'h01;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SDIV_LSB = 4;
  localparam int ARNG_LSB = 0;
  localparam int RESEL_EN_BIT = 6;
  localparam int SEL_EN_BIT = 5;
  localparam int OWNID_LSB = 0;
  localparam int PCODE_LSB = 5;
  localparam int OFS_LSB = 0;
  localparam int ROLE_BIT = 0;
  // ----------------------------------------
  // codes and counts
  // ----------------------------------------
  localparam logic [2:0] CODE_LAST_LEGAL = 3'h4;
  localparam logic [3:0] OFS_MAX = 4'h8;
  localparam logic [3:0] PERIOD_BASE = 4'h4;
  localparam logic [1:0] RX_DIV_LAST = 2'h3;
  // half-cycle accumulator thresholds: twice the division factor
  localparam logic [2:0] THR_DIV1 = 3'h2;
  localparam logic [2:0] THR_DIV1P5 = 3'h3;
  localparam logic [2:0] THR_DIV2 = 3'h4;
  localparam logic [2:0] THR_DIV3 = 3'h6;
  localparam logic [2:0] HALF_STEP = 3'h2;
  localparam logic [2:0] PH_DATA_OUT = 3'h0;
  localparam logic [2:0] PH_DATA_IN = 3'h1;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic sel_seen;
    logic resel_seen;
    logic [7:0] bus_ids;
    logic arb_active;
    logic [2:0] phase;
    logic req_sent;
    logic ack_seen;
  } stc_bus_evt_type;
  typedef struct packed {
    logic sync_clk_en;
    logic rx_tick;
    logic tx_tick;
    logic sync_xfer;
    logic offset_full;
    logic [3:0] max_offset;
    logic [2:0] async_clock_range;
  } stc_xfer_ctl_type;
  typedef struct packed {
    logic [2:0] send_period_code;
    logic [3:0] max_offset;
  } stc_ti_load_type;
endpackage

// ### src/stc_top.sv
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module stc_top
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire stc_bus_evt_type bus_evt,
  input wire logic [7:0] response_id_set,
  input wire logic ti_load,
  input wire logic [7:0] ti_data,
  output stc_xfer_ctl_type xfer_ctl,
  output logic role_target,
  output logic sel_respond,
  output logic resel_respond,
  output logic [7:0] arb_id_drive,
  output logic arb_won
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [5:0] word_idx(input logic [7:0] a);
    return a[7:2];
  endfunction

  function automatic logic is_mapped(input logic [5:0] i);
    return (i == IDX_CLKDIV) || (i == IDX_OWNID) || (i == IDX_PERIOD) ||
           (i == IDX_CTRL) || (i == IDX_STATUS);
  endfunction

  function automatic logic [7:0] one_hot(input logic [2:0] id);
    return 8'h01 << id;
  endfunction

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic rst_s1_r;
  logic rst_sync_b;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_sync_b <= rst_s1_r;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] clkdiv_r;
  logic [7:0] ownid_r;
  logic [7:0] period_r;
  logic [7:0] ctrl_r;
  logic [7:0] status_r;
  logic [5:0] aw_idx_r;
  logic [7:0] wbyte_r;
  logic wlane_r;
  logic do_write;
  logic [5:0] ar_idx;

  assign do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign ar_idx = word_idx(s_axi_araddr);

  // ----------------------------------------
  // axi write channel
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_idx_r <= '0;
      wbyte_r <= RST_REG;
      wlane_r <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_idx_r <= word_idx(s_axi_awaddr);
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wbyte_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  // masks drop writes to reserved positions so they always read zero
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      clkdiv_r <= RST_REG;
      ownid_r <= RST_REG;
      ctrl_r <= RST_REG;
    end else if (ce && do_write && wlane_r) begin
      unique case (aw_idx_r)
        IDX_CLKDIV: clkdiv_r <= wbyte_r & MASK_CLKDIV; // [RQ15]
        IDX_OWNID: ownid_r <= wbyte_r & MASK_OWNID; // [RQ15]
        IDX_CTRL: ctrl_r <= wbyte_r & MASK_CTRL;
        default: ;
      endcase
    end
  end

  // table-indirect load wins over a bus write landing in the same cycle
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      period_r <= RST_REG;
    end else if (ce) begin
      if (ti_load) begin
        period_r <= ti_data & MASK_PERIOD; // [RQ12] [RQ15]
      end else if (do_write && wlane_r && aw_idx_r == IDX_PERIOD) begin
        period_r <= wbyte_r & MASK_PERIOD; // [RQ15]
      end
    end
  end

  // ----------------------------------------
  // axi read channel
  // ----------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = RST_REG;
    unique case (ar_idx)
      IDX_CLKDIV: rd_byte = clkdiv_r;
      IDX_OWNID: rd_byte = ownid_r;
      IDX_PERIOD: rd_byte = period_r;
      IDX_CTRL: rd_byte = ctrl_r;
      IDX_STATUS: rd_byte = status_r;
      default: rd_byte = RST_REG;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  logic [2:0] sdiv;
  logic [2:0] arng;
  logic [2:0] own_id;
  logic [2:0] pcode;
  logic [3:0] ofs_code;
  logic [2:0] thr;
  logic [3:0] send_period_divisor;
  logic data_phase;
  logic ofs_legal;
  logic sync_allowed;

  assign sdiv = clkdiv_r[SDIV_LSB +: 3];
  assign arng = clkdiv_r[ARNG_LSB +: 3];
  assign own_id = ownid_r[OWNID_LSB +: 3];
  assign pcode = period_r[PCODE_LSB +: 3];
  assign ofs_code = period_r[OFS_LSB +: 4];
  assign send_period_divisor = PERIOD_BASE + {1'b0, pcode}; // [RQ11]
  assign data_phase = (bus_evt.phase == PH_DATA_OUT) || (bus_evt.phase == PH_DATA_IN);
  assign ofs_legal = ofs_code <= OFS_MAX; // [RQ13]
  // reserved offset codes fall back to asynchronous transfer
  assign sync_allowed = data_phase && ofs_legal && (ofs_code != 4'h0); // [RQ14] [RQ13]

  // reserved divisor codes stop the synchronous clock rather than guess a rate
  always_comb begin
    unique case (sdiv) // [RQ1]
      3'h0: thr = THR_DIV3;
      3'h1: thr = THR_DIV1;
      3'h2: thr = THR_DIV1P5;
      3'h3: thr = THR_DIV2;
      3'h4: thr = THR_DIV3;
      default: thr = 3'h0;
    endcase
  end

  // ----------------------------------------
  // synchronous clock divider
  // ----------------------------------------
  // counts in half cycles so that /1.5 gives two enables every three clocks
  logic [2:0] acc_r;
  logic [2:0] acc_sum;
  logic sync_en;

  assign acc_sum = acc_r + HALF_STEP;
  assign sync_en = (thr != 3'h0) && (acc_sum >= thr);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      acc_r <= 3'h0;
    end else if (ce) begin
      if (thr == 3'h0) begin
        acc_r <= 3'h0;
      end else if (sync_en) begin
        acc_r <= acc_sum - thr; // [RQ1]
      end else begin
        acc_r <= acc_sum;
      end
    end
  end

  // ----------------------------------------
  // receive and send rate dividers
  // ----------------------------------------
  logic [1:0] rx_cnt_r;
  logic [3:0] tx_cnt_r;
  logic rx_tick;
  logic tx_tick;

  assign rx_tick = sync_en && (rx_cnt_r == RX_DIV_LAST);
  assign tx_tick = sync_en && (tx_cnt_r == send_period_divisor - 4'h1);

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      rx_cnt_r <= 2'h0;
    end else if (ce && sync_en) begin
      rx_cnt_r <= rx_cnt_r + 2'h1; // [RQ2]
    end
  end

  // a period shortened below the running count restarts from zero at the next sync enable
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tx_cnt_r <= 4'h0;
    end else if (ce && sync_en) begin
      if (tx_cnt_r >= send_period_divisor - 4'h1) begin
        tx_cnt_r <= 4'h0; // [RQ3]
      end else begin
        tx_cnt_r <= tx_cnt_r + 4'h1; // [RQ3]
      end
    end
  end

  // ----------------------------------------
  // outstanding req/ack offset
  // ----------------------------------------
  logic [3:0] outst_r;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      outst_r <= 4'h0;
    end else if (ce) begin
      if (!sync_allowed) begin
        outst_r <= 4'h0; // [RQ14]
      end else if (bus_evt.req_sent && !bus_evt.ack_seen && outst_r < ofs_code) begin
        outst_r <= outst_r + 4'h1; // [RQ13]
      end else if (bus_evt.ack_seen && !bus_evt.req_sent && outst_r != 4'h0) begin
        outst_r <= outst_r - 4'h1;
      end
    end
  end

  // ----------------------------------------
  // transfer control outputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      xfer_ctl <= '0;
    end else if (ce) begin
      xfer_ctl.sync_clk_en <= sync_en; // [RQ1]
      xfer_ctl.rx_tick <= rx_tick; // [RQ2]
      xfer_ctl.tx_tick <= tx_tick; // [RQ3]
      xfer_ctl.sync_xfer <= sync_allowed; // [RQ14]
      xfer_ctl.max_offset <= sync_allowed ? ofs_code : 4'h0; // [RQ13]
      xfer_ctl.offset_full <= sync_allowed && (outst_r >= ofs_code);
      xfer_ctl.async_clock_range <= arng; // [RQ4]
    end
  end

  // ----------------------------------------
  // selection, reselection and role
  // ----------------------------------------
  logic id_hit;

  assign id_hit = (bus_evt.bus_ids & response_id_set) != 8'h00;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      sel_respond <= 1'b0;
      resel_respond <= 1'b0;
      role_target <= 1'b0;
    end else if (ce) begin
      sel_respond <= bus_evt.sel_seen && ownid_r[SEL_EN_BIT] && id_hit; // [RQ7]
      resel_respond <= bus_evt.resel_seen && ownid_r[RESEL_EN_BIT] && id_hit; // [RQ5]
      // role follows software only; being addressed never flips it
      role_target <= ctrl_r[ROLE_BIT]; // [RQ6] [RQ8]
    end
  end

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  logic [7:0] own_bit;
  logic [7:0] higher_ids;

  assign own_bit = one_hot(own_id);
  assign higher_ids = ~((own_bit << 1) - 8'h01) & ~own_bit;

  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      arb_id_drive <= 8'h00;
      arb_won <= 1'b0;
    end else if (ce) begin
      arb_id_drive <= bus_evt.arb_active ? own_bit : 8'h00; // [RQ9]
      arb_won <= bus_evt.arb_active && ((bus_evt.bus_ids & higher_ids) == 8'h00); // [RQ10]
    end
  end

  // ----------------------------------------
  // status
  // ----------------------------------------
  // flags a forbidden clock range so software sees its own mistake
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      status_r <= RST_REG;
    end else if (ce) begin
      status_r <= {arng > CODE_LAST_LEGAL, sdiv > CODE_LAST_LEGAL, !ofs_legal, // [RQ4]
                   sync_allowed, outst_r};
    end
  end

endmodule

// ### testbench/stc_bus_partner.sv
`timescale 1ns/1ps
module stc_bus_partner
  import stc_pkg::*;
(
  input wire logic clk,
  output stc_bus_evt_type evt
);
  logic s, r, a, rq, ak;
  logic [2:0] ph;
  logic [7:0] ids;
  initial begin
    {s, r, a, rq, ak, ph, ids} = '0;
    evt = '0;
  end
  always @(posedge clk) begin
    evt.sel_seen <= s;
    evt.resel_seen <= r;
    evt.arb_active <= a;
    evt.phase <= ph;
    evt.req_sent <= rq;
    evt.ack_seen <= ak;
    // a released data bus shows the complement of its last ids, flipping every clock
    evt.bus_ids <= (s || r || a) ? ids : ~evt.bus_ids;
  end
  task sel_pulse(input logic re, input logic [7:0] i);
    ids <= i;
    s <= !re;
    r <= re;
    @(posedge clk);
    {s, r} <= 2'b00;
    @(posedge clk);
  endtask
  task arb(input logic on, input logic [7:0] i);
    a <= on;
    ids <= i;
  endtask
  task set_phase(input logic [2:0] p);
    ph <= p;
  endtask
  task strobe(input logic req);
    rq <= req;
    ak <= !req;
    @(posedge clk);
    {rq, ak} <= 2'b00;
    @(posedge clk);
  endtask
endmodule

// ### testbench/stc_checker.sv
`timescale 1ns/1ps
module stc_checker
  import stc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic s_axi_bvalid,
  input wire stc_bus_evt_type bus_evt,
  input wire logic [7:0] response_id_set,
  input wire stc_xfer_ctl_type xfer_ctl,
  input wire logic role_target,
  input wire logic sel_respond,
  input wire logic resel_respond,
  input wire logic [7:0] arb_id_drive,
  input wire logic arb_won
);
  logic sel_hit;
  logic resel_hit;
  logic [7:0] above;
  assign sel_hit = bus_evt.sel_seen && |(bus_evt.bus_ids & response_id_set);
  assign resel_hit = bus_evt.resel_seen && |(bus_evt.bus_ids & response_id_set);
  // ids that outrank the one being driven
  assign above = ~((arb_id_drive << 1) - 8'h01);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_sel_answer: assert property (sel_respond |-> $past(sel_hit))
    else $error("selection answered without a hit");
  a_resel_answer: assert property (resel_respond |-> $past(resel_hit))
    else $error("reselection answered without a hit");
  a_arb_drive: assert property (bus_evt.arb_active |=> $onehot(arb_id_drive))
    else $error("own id not driven in arbitration");
  a_arb_idle: assert property (!bus_evt.arb_active |=> arb_id_drive == 8'h00)
    else $error("id driven outside arbitration");
  a_arb_prio: assert property (arb_won |-> ($past(bus_evt.bus_ids) & above) == 8'h00)
    else $error("won against a higher id");
  a_sync_phase: assert property (xfer_ctl.sync_xfer |-> $past(bus_evt.phase) <= 3'h1)
    else $error("sync transfer outside data phase");
  a_ofs_legal: assert property (xfer_ctl.sync_xfer |-> xfer_ctl.max_offset inside {[4'h1:4'h8]})
    else $error("sync with illegal offset");
  a_ofs_async: assert property (!xfer_ctl.sync_xfer |-> xfer_ctl.max_offset == 4'h0)
    else $error("offset shown while asynchronous");
  a_rx_space: assert property (xfer_ctl.rx_tick |=> !xfer_ctl.rx_tick [*3])
    else $error("receive ticks too close");
  a_tx_space: assert property (xfer_ctl.tx_tick |=> !xfer_ctl.tx_tick [*3])
    else $error("send ticks too close");
  a_role_write: assert property ($changed(role_target) |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("role changed without a write");
endmodule
bind stc_top stc_checker chk (.clk, .rst_b, .s_axi_bvalid, .bus_evt, .response_id_set, .xfer_ctl,
  .role_target, .sel_respond, .resel_respond, .arb_id_drive, .arb_won);

// ### testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import stc_pkg::*;
  localparam logic [7:0] A_DIV = {IDX_CLKDIV, 2'b00};
  localparam logic [7:0] A_OWN = {IDX_OWNID, 2'b00};
  localparam logic [7:0] A_PER = {IDX_PERIOD, 2'b00};
  localparam logic [7:0] A_CTL = {IDX_CTRL, 2'b00};
  logic clk, rst_b, ce, ti_load, role_target, sel_respond, resel_respond, arb_won;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, response_id_set, ti_data, arb_id_drive, seed, v, ids;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  stc_bus_evt_type bus_evt;
  stc_xfer_ctl_type xfer_ctl;
  int err_count, compares, ns, nr, nt;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] regs [3] = '{A_DIV, A_OWN, A_PER};
  logic [7:0] masks [3] = '{MASK_CLKDIV, MASK_OWNID, MASK_PERIOD};
  int twice [5] = '{6, 2, 3, 4, 6};
  stc_top dut (.clk, .rst_b, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bus_evt, .response_id_set,
    .ti_load, .ti_data, .xfer_ctl, .role_target, .sel_respond, .resel_respond, .arb_id_drive, .arb_won);
  stc_bus_partner far (.clk, .evt(bus_evt));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // one tick of slack: the window edges need not line up with the divider
  function logic near(input int n, input int e);
    return n >= e - 1 && n <= e + 1;
  endfunction
  task chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ad, wd;
    @(posedge clk);
    {ad, wd} = 2'b00;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    bq.push_back(r);
    while (!(ad && wd)) begin
      @(posedge clk);
      if (s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    rq.push_back({r, 24'h0, d});
    @(posedge clk);
    while (!s_axi_arready) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    @(posedge clk);
    while (!s_axi_rvalid) @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task count(input int n);
    {ns, nr, nt} = '0;
    repeat (8) @(posedge clk);
    repeat (n) begin
      @(posedge clk);
      ns += xfer_ctl.sync_clk_en;
      nr += xfer_ctl.rx_tick;
      nt += xfer_ctl.tx_tick;
    end
  endtask
  always @(posedge clk) begin
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      chk("bresp", s_axi_bresp, bq.pop_front());
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end
  initial begin
    #2000000;
    err_count++;
    test_done;
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ti_load, rst_b} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ti_data, response_id_set} = '0;
    {err_count, compares} = '0;
    ce = 1'b1;
    seed = 8'h2e;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    rd(8'h40, 8'h00, RESP_SLVERR);
    wr(8'h40, 8'hff, RESP_SLVERR);
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      v = i < 3 ? 8'hff : seed;
      if (i < 3)
        rd(regs[i], RST_REG, RESP_OKAY);
      wr(regs[i % 3], v, RESP_OKAY);
      rd(regs[i % 3], v & masks[i % 3], RESP_OKAY);
    end
    for (int c = 0; c < 6; c++) begin
      wr(A_DIV, {1'b0, c[2:0], 4'h0}, RESP_OKAY);
      count(60);
      chk("sync_cnt", near(ns, c < 5 ? 120 / twice[c % 5] : 0), 1'b1);
    end
    // software keeps to the legal range codes only
    for (int c = 0; c < 5; c++) begin
      wr(A_DIV, {4'h1, 1'b0, c[2:0]}, RESP_OKAY);
      @(posedge clk);
      #1;
      chk("arange", xfer_ctl.async_clock_range, c[2:0]);
    end
    for (int p = 0; p < 8; p++) begin
      wr(A_PER, {p[2:0], 5'h0}, RESP_OKAY);
      count(120);
      chk("rx_cnt", near(nr, 30), 1'b1);
      chk("tx_cnt", near(nt, 120 / (p + 4)), 1'b1);
    end
    for (int k = 0; k < 4; k++) begin
      v = k < 2 ? k * 3 : k + 6;
      wr(A_PER, v, RESP_OKAY);
      for (int ph = 0; ph < 8; ph++) begin
        far.set_phase(ph[2:0]);
        repeat (3) @(posedge clk);
        #1;
        chk("sync_xfer", xfer_ctl.sync_xfer, ph < 2 && v > 0 && v <= 8);
        chk("max_ofs", xfer_ctl.max_offset, (ph < 2 && v > 0 && v <= 8) ? v[3:0] : 4'h0);
      end
    end
    wr(A_PER, 8'h02, RESP_OKAY);
    far.set_phase(3'h1);
    far.strobe(1'b1);
    far.strobe(1'b1);
    repeat (3) @(posedge clk);
    #1;
    chk("full", xfer_ctl.offset_full, 1'b1);
    far.strobe(1'b0);
    repeat (3) @(posedge clk);
    #1;
    chk("full", xfer_ctl.offset_full, 1'b0);
    wr(A_CTL, 8'h01, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      wr(A_OWN, {1'b0, seed[1:0], 5'h0}, RESP_OKAY);
      response_id_set <= seed;
      ids = lfsr(seed) ^ 8'h5a;
      #1;
      far.sel_pulse(seed[2], ids);
      #1;
      chk("sel", sel_respond, !seed[2] && seed[0] && |(ids & seed));
      chk("resel", resel_respond, seed[2] && seed[1] && |(ids & seed));
      chk("role", role_target, 1'b1);
    end
    for (int k = 0; k < 8; k++) begin
      wr(A_OWN, {5'h0, k[2:0]}, RESP_OKAY);
      seed = lfsr(seed);
      ids = seed | (8'h01 << k);
      #1;
      far.arb(1'b1, ids);
      repeat (2) @(posedge clk);
      #1;
      chk("arb_id", arb_id_drive, 8'h01 << k);
      chk("arb_won", arb_won, (ids >> (k + 1)) == 8'h00);
    end
    far.arb(1'b0, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    chk("arb_id", arb_id_drive, 8'h00);
    seed = lfsr(seed);
    @(posedge clk);
    ti_data <= seed;
    ti_load <= 1'b1;
    @(posedge clk);
    ti_load <= 1'b0;
    rd(A_PER, seed & MASK_PERIOD, RESP_OKAY);
    // stop the sync ticks first so frozen tick outputs cannot trip the spacing checks
    wr(A_DIV, 8'h50, RESP_OKAY);
    repeat (2) @(posedge clk);
    {ce, ti_load} <= 2'b01;
    ti_data <= ~seed;
    @(posedge clk);
    {ce, ti_load} <= 2'b10;
    // a table load seen while the clock enable is low must not land
    rd(A_PER, seed & MASK_PERIOD, RESP_OKAY);
    test_done;
  end
endmodule
